// ==== design/pcd_params.svh ====
// pcd_params.svh: offsets, field positions, reset values and counts of the config pointer decode
// assumes: included by bare name from design files and the package
// What this block does
// - The configuration pointer is one 32-bit register whose fields pick the target of a config access.
// - Bits 23 to 16 of the pointer give the target bus number.
// - Bits 15 to 11 of the pointer give the five-bit device number.
// - Bits 10 to 8 of the pointer give the function number.
// - Bits 7 to 2 of the pointer give the doubleword index of the config register.
// - Each target has its select wired to one line of AD31 to AD11, which acts as its chip select.
// - The bus number together with the device number decides which select line is driven.
// - Device number n drives line 11 plus n, so device 20 drives line 31 and device 1 line 12.
// - Device 0 on the bridge's own bus is answered by the bridge itself, not by a target.
// - Only a full doubleword access to the pointer is a config setup; narrower ones pass on as I/O.
// - After the pointer is loaded with bit 31 set, data port accesses run a config transfer qualified by byte enables.
// - The pointer sits at I/O address 0CF8h and the data port at 0CFCh, both doubleword wide.
`ifndef PCD_PARAMS_SVH
`define PCD_PARAMS_SVH
`define PCD_PTR_ADDR 16'h0CF8
`define PCD_DATA_ADDR 16'h0CFC
`define PCD_PTR_RESET 32'h0000_0000
`define PCD_BUS_HI 23
`define PCD_BUS_LO 16
`define PCD_DEV_HI 15
`define PCD_DEV_LO 11
`define PCD_FUNC_HI 10
`define PCD_FUNC_LO 8
`define PCD_REG_HI 7
`define PCD_REG_LO 2
`define PCD_EN_BIT 31
`define PCD_SEL_BASE 11
`define PCD_DEV_MAX 5'h14
`define PCD_OWN_BUS 8'h00
`define PCD_ABSENT_DATA 32'hFFFF_FFFF
`define PCD_FULL_BE 4'hF
`define PCD_CFG_REGS 64
`endif

// ==== design/pcd_pkg.sv ====
// pcd_pkg.sv: types shared by the config pointer decode
// assumes: pcd_params.svh is on the include path
`include "pcd_params.svh"
package pcd_pkg;
	typedef enum logic [1:0] {
		PCD_IDLE,
		PCD_CYCLE,
		PCD_DONE
	} pcd_state_t;
	typedef logic [5:0] pcd_reg_idx_t;
endpackage

// ==== design/pcd_own_cfg_mem.sv ====
// pcd_own_cfg_mem.sv: the bridge's own config space, 64 doublewords with byte writes
// assumes: one clock; read data come out of a register one cycle after the request
`timescale 1ns/10ps
`include "pcd_params.svh"
module pcd_own_cfg_mem (
	// clock
	input wire logic clk_in,
	// access
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic [5:0] idx_in,
	input wire logic [3:0] be_in,
	input wire logic [31:0] wdata_in,
	output logic [31:0] rdata_out
);
	logic [31:0] mem [0:`PCD_CFG_REGS-1];

	always_ff @(posedge clk_in) begin
		for (int b = 0; b < 4; b++) begin
			if (wr_in && be_in[b]) begin
				mem[idx_in][b*8 +: 8] <= wdata_in[b*8 +: 8];
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rd_in) begin
			rdata_out <= mem[idx_in];
		end
	end
endmodule

// ==== design/pcd_cfg_decode.sv ====
// pcd_cfg_decode.sv: host I/O side config pointer, data port and select line decode
// assumes: host I/O requests are one-cycle strobes on clk_in; targets answer with a ready pulse
`timescale 1ns/10ps
`include "pcd_params.svh"
module pcd_cfg_decode (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// host I/O request
	input wire logic io_rd_in,
	input wire logic io_wr_in,
	input wire logic [15:0] io_addr_in,
	input wire logic [3:0] io_be_in,
	input wire logic [31:0] io_wdata_in,
	// host I/O answer
	output logic io_done_out,
	output logic [31:0] io_rdata_out,
	output logic io_pass_out,
	// pointer fields
	output logic [31:0] ptr_out,
	// config cycle toward PCI targets
	output logic cfg_req_out,
	output logic cfg_wr_out,
	output logic [20:0] idsel_out,
	output logic [7:0] cfg_bus_out,
	output logic [2:0] cfg_func_out,
	output logic [5:0] cfg_reg_out,
	output logic [3:0] cfg_be_out,
	output logic [31:0] cfg_wdata_out,
	input wire logic cfg_ack_in,
	input wire logic [31:0] cfg_rdata_in
);
	pcd_pkg::pcd_state_t state_r;
	logic [31:0] ptr_r;
	logic is_ptr_full;
	logic is_data;
	logic own_hit;
	logic absent;
	logic [31:0] own_rdata;
	logic own_rd_r;
	logic [4:0] dev;
	logic [7:0] bus;

	// one-hot select for device n on line 11+n, none beyond device 20
	function automatic logic [20:0] pcd_idsel(input logic [4:0] d);
		if (d > `PCD_DEV_MAX) begin
			return 21'h0_0000;
		end
		return 21'h0_0001 << d;
	endfunction

	assign bus = ptr_r[`PCD_BUS_HI:`PCD_BUS_LO];
	assign dev = ptr_r[`PCD_DEV_HI:`PCD_DEV_LO];
	assign ptr_out = ptr_r;
	// only full doubleword hits count; a byte or word at 0CF8h falls through to I/O
	assign is_ptr_full = (io_addr_in == `PCD_PTR_ADDR) && (io_be_in == `PCD_FULL_BE);
	assign is_data = (io_addr_in == `PCD_DATA_ADDR) && ptr_r[`PCD_EN_BIT];
	assign own_hit = (bus == `PCD_OWN_BUS) && (dev == 5'h00);
	assign absent = (bus == `PCD_OWN_BUS) && (dev > `PCD_DEV_MAX);
	assign io_pass_out = (io_rd_in || io_wr_in) && state_r == pcd_pkg::PCD_IDLE &&
		!is_ptr_full && !is_data;

	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ptr_r <= `PCD_PTR_RESET;
		end else if (io_wr_in && is_ptr_full && state_r == pcd_pkg::PCD_IDLE) begin
			ptr_r <= io_wdata_in;
		end
	end

	pcd_own_cfg_mem u_own (
		.clk_in(clk_in),
		.rd_in(io_rd_in && is_data && own_hit && state_r == pcd_pkg::PCD_IDLE),
		.wr_in(io_wr_in && is_data && own_hit && state_r == pcd_pkg::PCD_IDLE),
		.idx_in(ptr_r[`PCD_REG_HI:`PCD_REG_LO]),
		.be_in(io_be_in),
		.wdata_in(io_wdata_in),
		.rdata_out(own_rdata)
	);

	// data port state: external targets take a bus cycle, own space two cycles and absent ones one cycle
	always_ff @(posedge clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			state_r <= pcd_pkg::PCD_IDLE;
			cfg_req_out <= 1'b0;
			cfg_wr_out <= 1'b0;
			idsel_out <= 21'h0_0000;
			cfg_bus_out <= 8'h00;
			cfg_func_out <= 3'h0;
			cfg_reg_out <= 6'h00;
			cfg_be_out <= 4'h0;
			cfg_wdata_out <= 32'h0000_0000;
			io_done_out <= 1'b0;
			io_rdata_out <= 32'h0000_0000;
			own_rd_r <= 1'b0;
		end else begin
			io_done_out <= 1'b0;
			own_rd_r <= 1'b0;
			case (state_r)
				pcd_pkg::PCD_IDLE: begin
					if ((io_rd_in || io_wr_in) && is_ptr_full) begin
						io_done_out <= 1'b1;
						io_rdata_out <= ptr_r;
					end else if ((io_rd_in || io_wr_in) && is_data) begin
						if (own_hit) begin
							own_rd_r <= io_rd_in;
							state_r <= pcd_pkg::PCD_DONE;
						end else if (absent) begin
							io_done_out <= 1'b1;
							io_rdata_out <= `PCD_ABSENT_DATA;
						end else begin
							cfg_req_out <= 1'b1;
							cfg_wr_out <= io_wr_in;
							// a non-zero bus goes out with no select, for a bridge downstream
							idsel_out <= (bus == `PCD_OWN_BUS) ? pcd_idsel(dev) :
								21'h0_0000;
							cfg_bus_out <= bus;
							cfg_func_out <= ptr_r[`PCD_FUNC_HI:`PCD_FUNC_LO];
							cfg_reg_out <= ptr_r[`PCD_REG_HI:`PCD_REG_LO];
							cfg_be_out <= io_be_in;
							cfg_wdata_out <= io_wdata_in;
							state_r <= pcd_pkg::PCD_CYCLE;
						end
					end
				end
				pcd_pkg::PCD_CYCLE: begin
					if (cfg_ack_in) begin
						cfg_req_out <= 1'b0;
						idsel_out <= 21'h0_0000;
						io_done_out <= 1'b1;
						io_rdata_out <= cfg_wr_out ? 32'h0000_0000 : cfg_rdata_in;
						state_r <= pcd_pkg::PCD_IDLE;
					end
				end
				pcd_pkg::PCD_DONE: begin
					io_done_out <= 1'b1;
					io_rdata_out <= own_rd_r ? own_rdata : 32'h0000_0000;
					state_r <= pcd_pkg::PCD_IDLE;
				end
				default: begin
					state_r <= pcd_pkg::PCD_IDLE;
				end
			endcase
		end
	end
endmodule

// ==== verification/pcd_cfg_assertions.sv ====
// port checker for pcd_cfg_decode
// assumes a bind from the bench top and no strobe while a transfer is busy
`timescale 1ns/10ps
`include "pcd_params.svh"
module pcd_cfg_assertions (
	// host side
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic io_rd_in,
	input wire logic io_wr_in,
	input wire logic [15:0] io_addr_in,
	input wire logic [3:0] io_be_in,
	input wire logic [31:0] io_wdata_in,
	input wire logic io_done_out,
	input wire logic [31:0] io_rdata_out,
	input wire logic io_pass_out,
	input wire logic [31:0] ptr_out,
	// target side
	input wire logic cfg_req_out,
	input wire logic cfg_wr_out,
	input wire logic [20:0] idsel_out,
	input wire logic [7:0] cfg_bus_out,
	input wire logic [2:0] cfg_func_out,
	input wire logic [5:0] cfg_reg_out,
	input wire logic [3:0] cfg_be_out,
	input wire logic [31:0] cfg_wdata_out,
	input wire logic cfg_ack_in,
	input wire logic [31:0] cfg_rdata_in
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	wire dp = (io_rd_in | io_wr_in) && io_addr_in == `PCD_DATA_ADDR && ptr_out[31] && !cfg_req_out;
	wire own = ptr_out[23:11] == 13'h0000;
	wire absent = ptr_out[23:16] == `PCD_OWN_BUS && ptr_out[15:11] > `PCD_DEV_MAX;
	sequence ext_s; dp && !own && !absent; endsequence
	sequence ack_s; cfg_req_out && cfg_ack_in && !cfg_wr_out; endsequence
	ptr_load_a: assert property (io_wr_in && io_addr_in == `PCD_PTR_ADDR && io_be_in == `PCD_FULL_BE
		&& !cfg_req_out |=> io_done_out && ptr_out == $past(io_wdata_in)) else $error("ptr load");
	ptr_narrow_a: assert property (io_wr_in && io_addr_in == `PCD_PTR_ADDR && io_be_in != `PCD_FULL_BE
		|-> io_pass_out ##1 !io_done_out) else $error("narrow ptr");
	ext_start_a: assert property (ext_s |=> cfg_req_out) else $error("no cycle");
	ext_write_a: assert property (ext_s and io_wr_in |=> cfg_wr_out && cfg_be_out == $past(io_be_in)
		&& cfg_wdata_out == $past(io_wdata_in)) else $error("write lanes");
	idsel_map_a: assert property (cfg_req_out && cfg_bus_out == `PCD_OWN_BUS
		|-> idsel_out == 21'h1 << ptr_out[15:11]) else $error("idsel");
	bus_sel_a: assert property (cfg_req_out && cfg_bus_out != `PCD_OWN_BUS |-> idsel_out == 21'h0)
		else $error("bus sel");
	field_copy_a: assert property (cfg_req_out |-> cfg_bus_out == ptr_out[23:16]
		&& cfg_func_out == ptr_out[10:8] && cfg_reg_out == ptr_out[7:2]) else $error("fields");
	ack_done_a: assert property (ack_s |=> io_done_out && !cfg_req_out
		&& io_rdata_out == $past(cfg_rdata_in)) else $error("ack");
	absent_read_a: assert property (dp && absent && io_rd_in |=> io_done_out && !cfg_req_out
		&& io_rdata_out == `PCD_ABSENT_DATA) else $error("absent");
	own_space_a: assert property (dp && own |=> !cfg_req_out ##1 io_done_out) else $error("own");
endmodule

// ==== verification/pcd_pci_target.sv ====
// config target model on the far side of the decode
// assumes the decode's clock; the bench sets the answer delay
`timescale 1ns/10ps
module pcd_pci_target (
	// clock and delay
	input wire logic clk_in,
	input wire logic [3:0] wait_in,
	// config cycle
	input wire logic req_in,
	input wire logic [20:0] idsel_in,
	input wire logic [5:0] reg_in,
	output logic ack_out = 1'b0,
	output logic [31:0] rdata_out = 32'h0
);
	logic [3:0] n_r = 4'h0;
	always_ff @(posedge clk_in) begin
		if (req_in && !ack_out && n_r >= wait_in) begin
			ack_out <= 1'b1;
			// echo select and index so the bench sees which target answered
			rdata_out <= {5'h00, idsel_in, reg_in};
			n_r <= 4'h0;
		end else begin
			ack_out <= 1'b0;
			// released data keeps toggling so a late sample cannot pass
			rdata_out <= ~rdata_out;
			n_r <= (req_in && !ack_out) ? n_r + 4'h1 : 4'h0;
		end
	end
endmodule

// ==== verification/test_pcd_cfg_decode.sv ====
// bench for pcd_cfg_decode with one target model
// assumes the design files and pcd_params.svh compile first
`timescale 1ns/10ps
`include "pcd_params.svh"
module test_pcd_cfg_decode;
	logic clk_in = 1'b0, rst_b_in = 1'b0, io_rd_in = 1'b0, io_wr_in = 1'b0, ps;
	logic [15:0] io_addr_in = 16'h0000;
	logic [3:0] io_be_in = 4'hF, wt = 4'h0, cfg_be_out;
	logic [31:0] io_wdata_in = 32'h0, io_rdata_out, ptr_out, cfg_wdata_out, cfg_rdata_in, rd, p;
	logic io_done_out, io_pass_out, cfg_req_out, cfg_wr_out, cfg_ack_in;
	logic [20:0] idsel_out;
	logic [7:0] cfg_bus_out;
	logic [2:0] cfg_func_out;
	logic [5:0] cfg_reg_out;
	int n_fail = 0, n_tests = 0, i, dv[4] = '{1, 9, 20, 21};
	always #4 clk_in = ~clk_in;
	pcd_cfg_decode dut (.*);
	pcd_pci_target tgt (.clk_in(clk_in), .wait_in(wt), .req_in(cfg_req_out), .idsel_in(idsel_out),
		.reg_in(cfg_reg_out), .ack_out(cfg_ack_in), .rdata_out(cfg_rdata_in));
	task automatic finish_test();
		$display("checks %0d failures %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [3:0] b, input logic [31:0] d);
		@(posedge clk_in);
		io_rd_in <= !w;
		io_wr_in <= w;
		io_addr_in <= a;
		io_be_in <= b;
		io_wdata_in <= d;
		@(negedge clk_in);
		ps = io_pass_out;
		@(posedge clk_in);
		io_rd_in <= 1'b0;
		io_wr_in <= 1'b0;
		@(negedge clk_in);
		for (i = 0; i < 20 && !ps && io_done_out !== 1'b1; i++) @(negedge clk_in);
		if (i == 20) begin
			n_fail++;
			finish_test();
		end
		rd = io_rdata_out;
	endtask
	initial begin
		repeat (3) @(posedge clk_in);
		rst_b_in <= 1'b1;
		chk("ptr reset", 32'h0, ptr_out);
		acc(0, `PCD_DATA_ADDR, 4'hF, 32'h0);
		chk("data off", 32'h1, ps);
		acc(1, `PCD_PTR_ADDR, 4'h3, 32'h8000_0800);
		chk("narrow pass", 32'h1, ps);
		chk("narrow ptr", 32'h0, ptr_out);
		for (int k = 0; k < 4; k++) begin
			p = 32'h8000_0000 | (dv[k] << 11) | (k << 8) | ((k + 5) << 2);
			wt <= 4'(k * 3);
			acc(1, `PCD_PTR_ADDR, 4'hF, p);
			acc(0, `PCD_PTR_ADDR, 4'hF, 32'h0);
			chk("ptr read", p, rd);
			acc(0, `PCD_DATA_ADDR, 4'hF, 32'h0);
			chk("cfg read", dv[k] > 20 ? `PCD_ABSENT_DATA : {5'h00, 21'h1 << dv[k], 6'(k + 5)}, rd);
		end
		acc(1, `PCD_PTR_ADDR, 4'hF, 32'h8003_101C);
		acc(0, `PCD_DATA_ADDR, 4'hF, 32'h0);
		chk("bus read", 32'h7, rd);
		acc(1, `PCD_DATA_ADDR, 4'h5, 32'h1111_2222);
		acc(1, `PCD_PTR_ADDR, 4'hF, 32'h8000_000C);
		acc(1, `PCD_DATA_ADDR, 4'hF, 32'h1234_5678);
		acc(1, `PCD_DATA_ADDR, 4'h1, 32'hAABB_CCDD);
		acc(0, `PCD_DATA_ADDR, 4'hF, 32'h0);
		chk("own read", 32'h1234_56DD, rd);
		finish_test();
	end
endmodule
bind pcd_cfg_decode pcd_cfg_assertions sva (.*);
